// >>> common/cwp_consts.vh
// Constants for the configuration word protection decoder.
// Assumes a 25 MHz ref_clk and a 16-bit AXI4-Lite byte address.
//
// Notes on behaviour
// - Programmed bit reads 0, erased reads 1
// - Config words live at indices 2007h, 2008h
// - Programmer reaches config only in programming mode
// - Code guard 0 protects 0000h-0FFFh readout
// - Write guard field selects protected lower region
// - Data EEPROM guard 0 protects EEPROM contents
// - Debug bit picks GPIO or debugger pins
// - LOW_VOLTAGE_PROG_ENABLE bit gives pin programming function
// - Power-up delay after power-on, config enabled
// - Oscillator settle timer holds reset until stable
// - Sleep ends on reset, watchdog, enabled interrupt
`ifndef CWP_CONSTS_VH
`define CWP_CONSTS_VH

// ----------------------------------------
// Register indices, byte address is index * 4
// ----------------------------------------
`define CWP_IDX_CFG1    14'h2007
`define CWP_IDX_CFG2    14'h2008
`define CWP_IDX_STAT    14'h0000
`define CWP_IDX_CTRL    14'h0001
`define CWP_IDX_DEC     14'h0002

// ----------------------------------------
// Configuration word fields
// ----------------------------------------
`define CWP_WORD_W      14
`define CWP_WORD_ERASED 14'h3fff
`define CWP_B_CODE      13
`define CWP_B_DEBUG     11
`define CWP_B_WRT_HI    10
`define CWP_B_WRT_LO    9
`define CWP_B_EEG       8
`define CWP_B_LVP       7
`define CWP_B_POWER_UP_DELAY_TIMER      3
`define CWP_WRT_OFF     2'b11
`define CWP_WRT_LOW     2'b10
`define CWP_WRT_HALF    2'b01
`define CWP_LIM_LOW     12'h0ff
`define CWP_LIM_HALF    12'h7ff
`define CWP_LIM_ALL     12'hfff
`define CWP_CTRL_SLEEP  0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CWP_CLK_KHZ     25000
`define CWP_POWER_UP_DELAY_TIMER_MS     72
`define CWP_OST_CYC     1024
`define CWP_TMR_W       21

// ----------------------------------------
// AXI responses
// ----------------------------------------
`define CWP_RESP_OKAY   2'b00
`define CWP_RESP_SLV    2'b10
`define CWP_RESP_DEC    2'b11

`endif

// >>> rtl/cwp_timer.v
// Start-up hold timer: counts a load value down after a start pulse.
// Assumes start arrives only while idle.
`timescale 1ns/10ps
`include "cwp_consts.vh"

module cwp_timer (
    input  wire                 ref_clk,
    input  wire                 rst_n,
    input  wire                 start,
    input  wire [`CWP_TMR_W-1:0] limit,
    output wire                 busy
);
    reg [`CWP_TMR_W-1:0] cnt_q;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= {`CWP_TMR_W{1'b0}};
        end else if (start) begin
            cnt_q <= limit;
        end else if (cnt_q != {`CWP_TMR_W{1'b0}}) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign busy = (cnt_q != {`CWP_TMR_W{1'b0}});
endmodule

// >>> rtl/cwp_nvstore.v
// Non-volatile store for the two configuration words.
// Assumes the programmer drives prog_* synchronously to ref_clk.
`timescale 1ns/10ps
`include "cwp_consts.vh"

module cwp_nvstore (
    input  wire                  ref_clk,
    input  wire                  rst_n,
    input  wire                  prog_mode,
    input  wire                  prog_we,
    input  wire [13:0]           prog_addr,
    input  wire [`CWP_WORD_W-1:0] prog_wdata,
    output reg  [`CWP_WORD_W-1:0] prog_rdata,
    output wire [`CWP_WORD_W-1:0] word1,
    output wire [`CWP_WORD_W-1:0] word2
);
    reg  [`CWP_WORD_W-1:0] mem [0:1];
    wire                   hit1;
    wire                   hit2;
    integer                i;

    assign hit1 = (prog_addr == `CWP_IDX_CFG1);
    assign hit2 = (prog_addr == `CWP_IDX_CFG2);

    // Erased cells read as ones
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 2; i = i + 1) begin
                mem[i] <= `CWP_WORD_ERASED;
            end
            prog_rdata <= `CWP_WORD_ERASED;
        end else if (prog_mode) begin
            // Only the programmer in programming mode gets here
            if (prog_we && hit1) begin
                mem[0] <= prog_wdata;
            end
            if (prog_we && hit2) begin
                mem[1] <= prog_wdata;
            end
            prog_rdata <= hit1 ? mem[0] : (hit2 ? mem[1] : `CWP_WORD_ERASED);
        end
    end

    assign word1 = mem[0];
    assign word2 = mem[1];
endmodule

// >>> rtl/cwp_config_decode.v
// Configuration word decoder: captures the stored words at reset, decodes
// the protection and pin controls, runs start-up hold timers and sleep.
// Assumes a single 25 MHz clock; all inputs synchronous to it.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "cwp_consts.vh"

module cwp_config_decode #(
    parameter [`CWP_TMR_W-1:0] POWER_UP_DELAY_TIMER_CYC = `CWP_POWER_UP_DELAY_TIMER_MS * `CWP_CLK_KHZ,
    parameter [`CWP_TMR_W-1:0] OST_CYC  = `CWP_OST_CYC
) (
    input  wire                   ref_clk,
    input  wire                   rst_n,
    // AXI4-Lite slave
    input  wire [15:0]            s_axi_awaddr,
    input  wire                   s_axi_awvalid,
    output wire                   s_axi_awready,
    input  wire [31:0]            s_axi_wdata,
    input  wire [3:0]             s_axi_wstrb,
    input  wire                   s_axi_wvalid,
    output wire                   s_axi_wready,
    output reg  [1:0]             s_axi_bresp,
    output reg                    s_axi_bvalid,
    input  wire                   s_axi_bready,
    input  wire [15:0]            s_axi_araddr,
    input  wire                   s_axi_arvalid,
    output wire                   s_axi_arready,
    output reg  [31:0]            s_axi_rdata,
    output reg  [1:0]             s_axi_rresp,
    output reg                    s_axi_rvalid,
    input  wire                   s_axi_rready,
    // Programmer port
    input  wire                   prog_mode,
    input  wire                   prog_we,
    input  wire [13:0]            prog_addr,
    input  wire [`CWP_WORD_W-1:0] prog_wdata,
    output wire [`CWP_WORD_W-1:0] prog_rdata,
    // Start-up conditions
    input  wire                   por_flag,
    input  wire                   osc_is_crystal,
    // Sleep and wake
    input  wire                   cpu_sleep,
    input  wire                   ext_reset_wake,
    input  wire                   wdt_wake,
    input  wire                   irq_pending,
    input  wire                   irq_enabled,
    output reg                    sleeping,
    // Decoded controls
    output reg                    cpu_hold_reset,
    output reg                    program_code_guard,
    output reg                    flash_write_guard_on,
    output reg  [11:0]            flash_write_limit,
    input  wire [11:0]            nv_write_addr,
    output wire                   nv_write_blocked,
    output reg                    data_eeprom_guard,
    output reg                    dbg_pins_gpio,
    output reg                    low_voltage_prog_enable,
    output reg                    hv_prog_required
);
    // ----------------------------------------
    // Start-up sequencer states
    // ----------------------------------------
    localparam [3:0] ST_LOAD = 4'b0001;
    localparam [3:0] ST_POWER_UP_DELAY_TIMER = 4'b0010;
    localparam [3:0] ST_OST  = 4'b0100;
    localparam [3:0] ST_RUN  = 4'b1000;

    reg  [3:0]             state_q;
    reg  [3:0]             state_d;
    reg  [`CWP_WORD_W-1:0] cfg1_q;
    reg  [`CWP_WORD_W-1:0] cfg2_q;
    reg                    por_q;
    reg                    xtal_q;
    reg                    sleep_en_q;
    reg  [1:0]             wake_cause_q;
    wire [`CWP_WORD_W-1:0] word1;
    wire [`CWP_WORD_W-1:0] word2;
    wire                   power_up_delay_timer_busy;
    wire                   ost_busy;
    wire                   power_up_delay_timer_start;
    wire                   ost_start;
    wire [1:0]             wrt_field;
    wire                   wake_now;

    cwp_nvstore u_store (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .prog_mode  (prog_mode),
        .prog_we    (prog_we),
        .prog_addr  (prog_addr),
        .prog_wdata (prog_wdata),
        .prog_rdata (prog_rdata),
        .word1      (word1),
        .word2      (word2)
    );

    // ----------------------------------------
    // Capture at reset release
    // ----------------------------------------
    // Word is sampled once after reset, so a programmer
    // cannot change live protection
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg1_q <= `CWP_WORD_ERASED;
            cfg2_q <= `CWP_WORD_ERASED;
            por_q  <= 1'b0;
            xtal_q <= 1'b0;
        end else if (state_q == ST_LOAD) begin
            cfg1_q <= word1;
            cfg2_q <= word2;
            por_q  <= por_flag;
            xtal_q <= osc_is_crystal;
        end
    end

    // ----------------------------------------
    // Start-up sequencer
    // ----------------------------------------
    assign power_up_delay_timer_start = (state_q == ST_LOAD) && por_flag && !word1[`CWP_B_POWER_UP_DELAY_TIMER];
    assign ost_start  = (state_q == ST_POWER_UP_DELAY_TIMER) && !power_up_delay_timer_busy && xtal_q;

    cwp_timer u_power_up_delay_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .start   (power_up_delay_timer_start),
        .limit   (POWER_UP_DELAY_TIMER_CYC),
        .busy    (power_up_delay_timer_busy)
    );

    cwp_timer u_ost (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .start   (ost_start),
        .limit   (OST_CYC),
        .busy    (ost_busy)
    );

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_LOAD: begin
                state_d = ST_POWER_UP_DELAY_TIMER;
            end
            ST_POWER_UP_DELAY_TIMER: begin
                // Delay only after power-on and when enabled
                if (!power_up_delay_timer_busy) begin
                    state_d = xtal_q ? ST_OST : ST_RUN;
                end
            end
            ST_OST: begin
                // Hold until crystal settle count ends
                if (!ost_busy && !ost_start) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_LOAD;
            end
        endcase
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q        <= ST_LOAD;
            cpu_hold_reset <= 1'b1;
        end else begin
            state_q        <= state_d;
            cpu_hold_reset <= (state_d != ST_RUN);
        end
    end

    // ----------------------------------------
    // Decode, zero means programmed
    // ----------------------------------------
    assign wrt_field = {cfg1_q[`CWP_B_WRT_HI], cfg1_q[`CWP_B_WRT_LO]};

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            program_code_guard      <= 1'b0;
            flash_write_guard_on    <= 1'b0;
            flash_write_limit       <= `CWP_LIM_ALL;
            data_eeprom_guard       <= 1'b0;
            dbg_pins_gpio           <= 1'b1;
            low_voltage_prog_enable <= 1'b1;
            hv_prog_required        <= 1'b0;
        end else begin
            program_code_guard   <= !cfg1_q[`CWP_B_CODE];
            flash_write_guard_on <= (wrt_field != `CWP_WRT_OFF);
            case (wrt_field)
                `CWP_WRT_LOW:  flash_write_limit <= `CWP_LIM_LOW;
                `CWP_WRT_HALF: flash_write_limit <= `CWP_LIM_HALF;
                default:       flash_write_limit <= `CWP_LIM_ALL;
            endcase
            data_eeprom_guard       <= !cfg1_q[`CWP_B_EEG];
            dbg_pins_gpio           <= cfg1_q[`CWP_B_DEBUG];
            low_voltage_prog_enable <= cfg1_q[`CWP_B_LVP];
            hv_prog_required        <= !cfg1_q[`CWP_B_LVP];
        end
    end

    // Region starts at 0000h, so only the upper bound matters
    assign nv_write_blocked = flash_write_guard_on &&
                              (nv_write_addr <= flash_write_limit);

    // ----------------------------------------
    // Sleep
    // ----------------------------------------
    assign wake_now = ext_reset_wake || wdt_wake || (irq_pending && irq_enabled);

    // Wake wins over a same-cycle sleep request
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleeping     <= 1'b0;
            wake_cause_q <= 2'b00;
        end else if (sleeping && wake_now) begin
            sleeping     <= 1'b0;
            wake_cause_q <= ext_reset_wake ? 2'b01 : (wdt_wake ? 2'b10 : 2'b11);
        end else if (cpu_sleep && sleep_en_q && state_q == ST_RUN && !wake_now) begin
            sleeping <= 1'b1;
        end
    end

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    reg        aw_got_q;
    reg        w_got_q;
    reg [13:0] aw_idx_q;
    reg [31:0] w_data_q;
    reg [3:0]  w_strb_q;

    assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_q && !s_axi_bvalid;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            aw_idx_q     <= 14'h0000;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CWP_RESP_OKAY;
            sleep_en_q   <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr[15:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q  <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (aw_got_q && w_got_q && !s_axi_bvalid) begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_idx_q == `CWP_IDX_CTRL) begin
                    s_axi_bresp <= `CWP_RESP_OKAY;
                    if (w_strb_q[0]) begin
                        sleep_en_q <= w_data_q[`CWP_CTRL_SLEEP];
                    end
                end else if (aw_idx_q == `CWP_IDX_CFG1 || aw_idx_q == `CWP_IDX_CFG2 ||
                             aw_idx_q == `CWP_IDX_STAT || aw_idx_q == `CWP_IDX_DEC) begin
                    // Config is read-only from software
                    s_axi_bresp <= `CWP_RESP_SLV;
                end else begin
                    s_axi_bresp <= `CWP_RESP_DEC;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    wire [13:0] ar_idx;

    assign ar_idx        = s_axi_araddr[15:2];
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `CWP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `CWP_RESP_OKAY;
            case (ar_idx)
                `CWP_IDX_CFG1: s_axi_rdata <= {18'h00000, cfg1_q};
                `CWP_IDX_CFG2: s_axi_rdata <= {18'h00000, cfg2_q};
                `CWP_IDX_STAT: s_axi_rdata <= {22'h000000, wake_cause_q, prog_mode,
                                               por_q, xtal_q, sleeping, state_q};
                `CWP_IDX_CTRL: s_axi_rdata <= {31'h00000000, sleep_en_q};
                `CWP_IDX_DEC:  s_axi_rdata <= {12'h000, flash_write_limit,
                                               hv_prog_required, low_voltage_prog_enable,
                                               dbg_pins_gpio, data_eeprom_guard,
                                               flash_write_guard_on, program_code_guard,
                                               cpu_hold_reset, 1'b0};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `CWP_RESP_DEC;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// >>> testbench/cwp_checker_sva.sv
// Checker for the configuration decoder: bus answers, decode and sleep.
// Assumes it is bound to cwp_config_decode and sees only its ports.
`timescale 1ns/10ps
`include "cwp_consts.vh"
module cwp_checker #(
    parameter [`CWP_TMR_W-1:0] POWER_UP_DELAY_TIMER_CYC = 21'd20,
    parameter [`CWP_TMR_W-1:0] OST_CYC  = 21'd8
) (
    input wire        ref_clk,
    input wire        rst_n,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    input wire        sleeping,
    input wire        ext_reset_wake,
    input wire        wdt_wake,
    input wire        irq_pending,
    input wire        irq_enabled,
    input wire        cpu_hold_reset,
    input wire        program_code_guard,
    input wire        flash_write_guard_on,
    input wire [11:0] flash_write_limit,
    input wire [11:0] nv_write_addr,
    input wire        nv_write_blocked,
    input wire        data_eeprom_guard,
    input wire        dbg_pins_gpio,
    input wire        low_voltage_prog_enable,
    input wire        hv_prog_required
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Start-up hold length; counts only while the core is held
    reg [21:0] hold_cnt_q;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) hold_cnt_q <= 22'h0;
        else if (cpu_hold_reset) hold_cnt_q <= hold_cnt_q + 22'h1;
    end

    sequence s_wake_src;
        sleeping && (ext_reset_wake || wdt_wake || (irq_pending && irq_enabled));
    endsequence
    sequence s_no_wake;
        sleeping && !ext_reset_wake && !wdt_wake && !(irq_pending && irq_enabled);
    endsequence

    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");
    a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_write_blocked: assert property (nv_write_blocked ==
        (flash_write_guard_on && nv_write_addr <= flash_write_limit))
        else $error("write block mismatch");
    a_hv_entry: assert property (hv_prog_required != low_voltage_prog_enable)
        else $error("programming entry mismatch");
    a_guards_steady: assert property (!$past(cpu_hold_reset) && !cpu_hold_reset |->
        $stable({program_code_guard, flash_write_guard_on, flash_write_limit,
        data_eeprom_guard, dbg_pins_gpio, low_voltage_prog_enable}))
        else $error("decoded controls changed");
    a_hold_bounded: assert property (hold_cnt_q <=
        {1'b0, POWER_UP_DELAY_TIMER_CYC} + {1'b0, OST_CYC} + 22'h4) else $error("start-up hold too long");
    a_hold_awake: assert property (cpu_hold_reset |-> !sleeping)
        else $error("sleep during start-up hold");
    a_wake_any: assert property (s_wake_src |=> !sleeping)
        else $error("wake ignored");
    a_stay_asleep: assert property (s_no_wake |=> sleeping)
        else $error("woke without cause");
endmodule

bind cwp_config_decode cwp_checker #(.POWER_UP_DELAY_TIMER_CYC(POWER_UP_DELAY_TIMER_CYC), .OST_CYC(OST_CYC)) cwp_checker_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .sleeping(sleeping), .ext_reset_wake(ext_reset_wake),
    .wdt_wake(wdt_wake), .irq_pending(irq_pending), .irq_enabled(irq_enabled),
    .cpu_hold_reset(cpu_hold_reset), .program_code_guard(program_code_guard),
    .flash_write_guard_on(flash_write_guard_on), .flash_write_limit(flash_write_limit),
    .nv_write_addr(nv_write_addr), .nv_write_blocked(nv_write_blocked),
    .data_eeprom_guard(data_eeprom_guard), .dbg_pins_gpio(dbg_pins_gpio),
    .low_voltage_prog_enable(low_voltage_prog_enable), .hv_prog_required(hv_prog_required));

// >>> testbench/cwp_prog_model.sv
// Programmer model: writes and reads the configuration words.
// Assumes the decoder samples the programmer lines on the rising ref_clk edge.
`timescale 1ns/10ps
module cwp_prog_model (
    input  wire        ref_clk,
    output reg         prog_mode,
    output reg         prog_we,
    output reg  [13:0] prog_addr,
    output reg  [13:0] prog_wdata,
    input  wire [13:0] prog_rdata
);
    initial begin
        prog_mode = 1'b0;
        prog_we = 1'b0;
        prog_addr = 14'h0;
        prog_wdata = 14'h0;
    end

    // Mode low gives a stray write from outside programming mode
    task put_word(input m, input [13:0] a, input [13:0] d);
        begin
            @(posedge ref_clk);
            prog_mode <= m;
            prog_we <= 1'b1;
            prog_addr <= a;
            prog_wdata <= d;
            @(posedge ref_clk);
            prog_we <= 1'b0;
            prog_wdata <= ~d;
        end
    endtask

    task get_word(input [13:0] a, output [13:0] d);
        begin
            @(posedge ref_clk);
            prog_mode <= 1'b1;
            prog_addr <= a;
            @(posedge ref_clk);
            @(posedge ref_clk);
            d = prog_rdata;
        end
    endtask

    // Released address lines show a changed pattern, not the last value
    task leave;
        begin
            @(posedge ref_clk);
            prog_mode <= 1'b0;
            prog_addr <= ~prog_addr;
        end
    endtask
endmodule

// >>> testbench/tb_top.sv
// Testbench for the configuration word decoder.
// Assumes the checker and the programmer model are compiled before it.
`timescale 1ns/10ps
`include "cwp_consts.vh"
module tb_top;
    localparam [20:0] OSCILLATOR_SETTLE_TIMER = 21'd8;
    reg         ref_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg         s_axi_arvalid, s_axi_rready, por_flag, osc_is_crystal, cpu_sleep;
    reg         ext_reset_wake, wdt_wake, irq_pending, irq_enabled;
    reg  [15:0] s_axi_awaddr, s_axi_araddr;
    reg  [31:0] s_axi_wdata;
    reg  [3:0]  s_axi_wstrb;
    reg  [11:0] nv_write_addr;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire        prog_mode, prog_we, sleeping, cpu_hold_reset, program_code_guard;
    wire        flash_write_guard_on, nv_write_blocked, data_eeprom_guard;
    wire        dbg_pins_gpio, low_voltage_prog_enable, hv_prog_required;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [13:0] prog_addr, prog_wdata, prog_rdata;
    wire [11:0] flash_write_limit;
    integer     num_errors, checks, n, i;
    reg  [13:0] w;

    cwp_config_decode #(.POWER_UP_DELAY_TIMER_CYC(21'd20), .OST_CYC(OSCILLATOR_SETTLE_TIMER)) cwp_config_decode_inst (.*);

    cwp_prog_model cwp_prog_model_inst (.*);

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task check(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task axi_wr(input [15:0] a, input [31:0] d, input [1:0] er);
        begin
            n = 0;
            @(posedge ref_clk);
            s_axi_awaddr <= a;
            s_axi_awvalid <= 1'b1;
            s_axi_wdata <= d;
            s_axi_wstrb <= 4'hf;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            @(posedge ref_clk);
            while (s_axi_bvalid !== 1'b1 && n < 20) begin
                if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
                if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
                n = n + 1;
                @(posedge ref_clk);
            end
            s_axi_bready <= 1'b0;
            check({n < 20, 29'h0, s_axi_bresp}, {1'b1, 29'h0, er});
        end
    endtask

    task axi_rd(input [15:0] a, input [31:0] m, input [31:0] ed, input [1:0] er);
        begin
            n = 0;
            @(posedge ref_clk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            @(posedge ref_clk);
            while (s_axi_rvalid !== 1'b1 && n < 20) begin
                if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
                n = n + 1;
                @(posedge ref_clk);
            end
            s_axi_rready <= 1'b0;
            check({n < 20, 29'h0, s_axi_rresp}, {1'b1, 29'h0, er});
            check(s_axi_rdata & m, ed);
        end
    endtask

    task complete_run;
        begin
            $display("checks %0d errors %0d", checks, num_errors);
            if (num_errors == 0 && checks > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Whole run is about a hundred cycles
    initial begin
        #(40 * 5000);
        num_errors = num_errors + 1;
        complete_run;
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h0;
        {s_axi_rready, cpu_sleep, ext_reset_wake, wdt_wake, irq_pending} = 5'h0;
        {irq_enabled, por_flag, osc_is_crystal} = 3'b011;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
        s_axi_wstrb = 4'h0;
        nv_write_addr = 12'h0;
        num_errors = 0;
        checks = 0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        // Erased word: delay timer off, only the crystal settle time holds
        i = 0;
        @(posedge ref_clk);
        while (cpu_hold_reset !== 1'b0 && i < 100) begin
            i = i + 1;
            @(posedge ref_clk);
        end
        check({31'h0, i >= OSCILLATOR_SETTLE_TIMER && i <= OSCILLATOR_SETTLE_TIMER + 4}, 32'h1);
        axi_rd(16'h0008, 32'hffffe, 32'hfff60, `CWP_RESP_OKAY);
        check({31'h0, nv_write_blocked}, 32'h0);
        axi_rd(16'h801c, 32'hffffffff, 32'h3fff, `CWP_RESP_OKAY);
        axi_rd(16'h8020, 32'hffffffff, 32'h3fff, `CWP_RESP_OKAY);
        axi_rd(16'h4000, 32'hffffffff, 32'h0, `CWP_RESP_DEC);
        axi_wr(16'h801c, 32'h0, `CWP_RESP_SLV);
        axi_rd(16'h801c, 32'hffffffff, 32'h3fff, `CWP_RESP_OKAY);
        cwp_prog_model_inst.put_word(1'b0, 14'h2007, 14'h0);
        cwp_prog_model_inst.get_word(14'h2007, w);
        check({18'h0, w}, 32'h3fff);
        cwp_prog_model_inst.put_word(1'b1, 14'h2007, 14'h0);
        cwp_prog_model_inst.get_word(14'h2007, w);
        check({18'h0, w}, 32'h0);
        cwp_prog_model_inst.get_word(14'h2006, w);
        check({18'h0, w}, 32'h3fff);
        cwp_prog_model_inst.leave;
        axi_rd(16'h0008, 32'hffffe, 32'hfff60, `CWP_RESP_OKAY);
        axi_rd(16'h0004, 32'h1, 32'h0, `CWP_RESP_OKAY);
        axi_wr(16'h0004, 32'h1, `CWP_RESP_OKAY);
        // Third pass holds the interrupt masked first: sleep must persist
        for (i = 1; i <= 3; i = i + 1) begin
            @(posedge ref_clk);
            cpu_sleep <= 1'b1;
            @(posedge ref_clk);
            cpu_sleep <= 1'b0;
            @(posedge ref_clk);
            check({31'h0, sleeping}, 32'h1);
            ext_reset_wake <= (i == 1);
            wdt_wake <= (i == 2);
            irq_pending <= (i == 3);
            repeat (2) @(posedge ref_clk);
            check({31'h0, sleeping}, {31'h0, i == 3});
            irq_enabled <= 1'b1;
            repeat (2) @(posedge ref_clk);
            check({31'h0, sleeping}, 32'h0);
            {ext_reset_wake, wdt_wake, irq_pending, irq_enabled} <= 4'h0;
            axi_rd(16'h0000, 32'h300, i << 8, `CWP_RESP_OKAY);
        end
        complete_run;
    end
endmodule
